// ### mcra_pkg.sv
/*
  mcra_pkg: constants and carrier types of the memory controller with
  remap and abort logic.
  assumes: one 125 MHz clock, synchronous active-high reset.
*/
// Overview of operation
// - strap low last 80 cycles: tri-state
// - split space: memories, external, peripherals
// - little-endian byte lanes only
// - after remap, primary sram at zero
// - extended bank decoded at 0x0010_0000
// - boot strap sampled last 10 cycles
// - strap picks external or internal boot memory
// - writing remap command bit swaps memories
// - chip selects 1..7 only after remap
// - remap sticks until a reset
// - abort on undefined external address
// - protected write aborts but still happens
// - no abort internal reads or peripherals
// - external unit serves middle region
// - per-bank waits, float, width
// - byte-select or byte-write on 16-bit bank
// - peripheral accesses forced to words
// - peripheral windows 16k, interrupt unit 4k
// - control register write-one commands
// - enable/disable registers drive status bits
package mcra_pkg;

  localparam int          STRAP_TRI_CYC    = 80;
  localparam int          STRAP_BOOT_CYC   = 10;
  localparam logic [31:0] INT_MEM_TOP      = 32'h0040_0000;
  localparam logic [31:0] PERIPH_BASE      = 32'hFFC0_0000;
  localparam logic [31:0] EXT_SRAM_BASE    = 32'h0010_0000;
  localparam logic [31:0] EXT_SRAM_SIZE    = 32'h0002_0000;
  localparam logic [31:0] PRIM_SRAM_BASE   = 32'h0030_0000;
  localparam logic [31:0] PRIM_SRAM_SIZE   = 32'h0000_2000;
  localparam logic [31:0] VEC_TOP          = 32'h0000_0020;
  localparam logic [31:0] ICU_BASE         = 32'hFFFF_F000;
  localparam logic [13:0] PERIPH_WIN_MASK  = 14'h3FFF;
  localparam logic [11:0] ICU_WIN_MASK     = 12'hFFF;
  localparam logic [31:0] REMAP_CTRL_ADDR  = 32'hFFE0_0020;
  localparam int          REMAP_BIT_POS    = 0;
  localparam int          NUM_BANKS        = 8;
  localparam logic [2:0]  BOOT_CS          = 3'h0;

  typedef enum logic [3:0] {
    MCRA_TGT_NONE = 4'b0001,
    MCRA_TGT_INT  = 4'b0010,
    MCRA_TGT_EXT  = 4'b0100,
    MCRA_TGT_PER  = 4'b1000
  } mcra_tgt_t;

  // processor request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [1:0]  size;   // 0 byte, 1 half, 2 word
    logic [31:0] addr;
    logic [31:0] wdata;
  } mcra_req_t;

  // one external bank setting
  typedef struct packed {
    logic        enable;
    logic [31:0] base;
    logic [31:0] size;
    logic [3:0]  waits;
    logic [1:0]  float_cyc;
    logic        wide16;
    logic        byte_write;
  } mcra_bank_t;

  // routed access to the far side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  lanes;
    logic [2:0]  cs;
    logic [3:0]  waits;
    logic [1:0]  float_cyc;
    logic        wide16;
    logic        byte_write;
  } mcra_route_t;

  // little-endian lane enables
  function automatic logic [3:0] mcra_lanes(input logic [1:0] sz,
                                            input logic [1:0] a);
    case (sz)
      2'h0:    mcra_lanes = 4'h1 << a;
      2'h1:    mcra_lanes = a[1] ? 4'hC : 4'h3;
      default: mcra_lanes = 4'hF;
    endcase
  endfunction

endpackage

// ### mcra_strap.sv
/*
  mcra_strap: catches tri-state and boot straps before reset release.
  assumes: straps synchronous to clock; external reset low-active pin.
*/
`timescale 1ns/1ps
module mcra_strap
  import mcra_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // pins
  input  wire logic external_reset_n,
  input  wire logic tristate_strap_n,
  input  wire logic boot_select_strap,
  // caught modes
  output logic      tristate_mode,
  output logic      boot_sel
);

  logic [6:0] tri_low_cnt_r;
  logic [3:0] boot_hi_cnt_r;
  logic [3:0] boot_lo_cnt_r;
  logic       rst_d_r;

  // count strap history while the pin reset is held
  always_ff @(posedge clock) begin
    if (reset || external_reset_n) begin
      tri_low_cnt_r <= 7'h00;
      boot_hi_cnt_r <= 4'h0;
      boot_lo_cnt_r <= 4'h0;
    end else begin
      tri_low_cnt_r <= tristate_strap_n ? 7'h00 :
        (tri_low_cnt_r == 7'(STRAP_TRI_CYC) ? tri_low_cnt_r
                                            : tri_low_cnt_r + 7'h01);
      boot_hi_cnt_r <= !boot_select_strap ? 4'h0 :
        (boot_hi_cnt_r == 4'(STRAP_BOOT_CYC) ? boot_hi_cnt_r
                                             : boot_hi_cnt_r + 4'h1);
      boot_lo_cnt_r <= boot_select_strap ? 4'h0 :
        (boot_lo_cnt_r == 4'(STRAP_BOOT_CYC) ? boot_lo_cnt_r
                                             : boot_lo_cnt_r + 4'h1);
    end
  end

  always_ff @(posedge clock) begin
    rst_d_r <= reset ? 1'b0 : !external_reset_n;
  end

  // latch at the pin release; the synchronous reset clears both modes
  always_ff @(posedge clock) begin
    if (reset) begin
      tristate_mode <= 1'b0;
      boot_sel      <= 1'b0;
    end else if (rst_d_r && external_reset_n) begin
      tristate_mode <= (tri_low_cnt_r == 7'(STRAP_TRI_CYC));
      // a boot strap that moved late keeps the previous mode
      if (boot_hi_cnt_r == 4'(STRAP_BOOT_CYC))
        boot_sel <= 1'b1;
      else if (boot_lo_cnt_r == 4'(STRAP_BOOT_CYC))
        boot_sel <= 1'b0;
    end
  end

endmodule // mcra_strap

// ### mcra_bitset.sv
/*
  mcra_bitset: enable/disable/status register set for one peripheral.
  assumes: write strobes are single-cycle, word data.
*/
`timescale 1ns/1ps
module mcra_bitset
  import mcra_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // command writes
  input  wire logic        en_wr,
  input  wire logic        dis_wr,
  input  wire logic [31:0] wdata,
  // state
  output logic [31:0]      status
);

  // enable wins over disable in the same cycle
  always_ff @(posedge clock) begin
    if (reset)
      status <= 32'h0000_0000;
    else
      status <= (status & ~(dis_wr ? wdata : 32'h0000_0000))
                | (en_wr ? wdata : 32'h0000_0000);
  end

endmodule // mcra_bitset

// ### mcra_ctrl.sv
/*
  mcra_ctrl: address decode, remap, abort generation and peripheral
  word forcing between the processor and memories, external bus and
  peripheral bus.
  assumes: one access presented per cycle; answers routed next cycle.
*/
`timescale 1ns/1ps
module mcra_ctrl
  import mcra_pkg::*;
#(
  parameter logic HAS_EXT_BANK = 1'b1,
  parameter logic EXT_IS_ROM   = 1'b0
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // pins
  input  wire logic        external_reset_n,
  input  wire logic        tristate_strap_n,
  input  wire logic        boot_select_strap,
  // processor side
  input  wire mcra_req_t   req,
  // external bank settings
  input  wire mcra_bank_t  bank [NUM_BANKS],
  input  wire logic        ext_protect,
  // peripheral enable/disable set
  input  wire logic        pset_en_wr,
  input  wire logic        pset_dis_wr,
  // outputs
  output mcra_route_t      int_acc,
  output mcra_route_t      ext_acc,
  output mcra_route_t      per_acc,
  output logic             int_sel_ext_bank,
  output logic             abort,
  output logic             remapped,
  output logic             tristate_mode,
  output logic             boot_sel,
  output logic [31:0]      ctrl_cmd,
  output logic [31:0]      pset_status
);

  logic        tri_w;
  logic        boot_w;
  logic [31:0] pset_w;
  logic        remap_r;
  mcra_tgt_t   tgt;
  logic        ext_hit;
  logic [2:0]  ext_cs;
  logic        int_ext_bank;
  logic        int_valid;
  logic [31:0] int_addr;
  logic        remap_wr;
  logic [31:0] per_addr;

  mcra_strap u_strap (
    .clock             (clock),
    .reset             (reset),
    .external_reset_n  (external_reset_n),
    .tristate_strap_n  (tristate_strap_n),
    .boot_select_strap (boot_select_strap),
    .tristate_mode     (tri_w),
    .boot_sel          (boot_w)
  );

  mcra_bitset u_pset (
    .clock  (clock),
    .reset  (reset),
    .en_wr  (pset_en_wr),
    .dis_wr (pset_dis_wr),
    .wdata  (req.wdata),
    .status (pset_w)
  );

  // region split by address
  always_comb begin
    if (!req.valid)
      tgt = MCRA_TGT_NONE;
    else if (req.addr < INT_MEM_TOP)
      tgt = MCRA_TGT_INT;
    else if (req.addr >= PERIPH_BASE)
      tgt = MCRA_TGT_PER;
    else
      tgt = MCRA_TGT_EXT;
  end

  // external bank lookup; only boot chip select before remap
  always_comb begin
    ext_hit = 1'b0;
    ext_cs  = BOOT_CS;
    for (int i = NUM_BANKS - 1; i >= 0; i--) begin
      if (bank[i].enable && req.addr >= bank[i].base
          && req.addr - bank[i].base < bank[i].size
          && (remap_r || 3'(i) == BOOT_CS)) begin
        ext_hit = 1'b1;
        ext_cs  = 3'(i);
      end
    end
  end

  // internal decode with remap swap of address zero
  always_comb begin
    int_valid    = 1'b0;
    int_ext_bank = 1'b0;
    int_addr     = req.addr;
    if (req.addr < PRIM_SRAM_SIZE && remap_r) begin
      int_valid = 1'b1;
      int_addr  = PRIM_SRAM_BASE | req.addr;
    end else if (HAS_EXT_BANK && req.addr >= EXT_SRAM_BASE
                 && req.addr < EXT_SRAM_BASE + EXT_SRAM_SIZE) begin
      int_valid    = 1'b1;
      int_ext_bank = 1'b1;
    end else if (!remap_r && req.addr < EXT_SRAM_SIZE && boot_w
                 && HAS_EXT_BANK) begin
      int_valid    = 1'b1;
      int_ext_bank = 1'b1;
      int_addr     = EXT_SRAM_BASE | req.addr;
    end else if (req.addr >= PRIM_SRAM_BASE
                 && req.addr < PRIM_SRAM_BASE + PRIM_SRAM_SIZE) begin
      int_valid = 1'b1;
    end
  end

  // boot from external chip select zero before remap
  logic boot_ext;
  assign boot_ext = !remap_r && (!boot_w || !HAS_EXT_BANK)
                    && req.addr < INT_MEM_TOP
                    && tgt == MCRA_TGT_INT && !int_valid;

  // peripheral addresses forced to word alignment
  assign per_addr = {req.addr[31:2], 2'b00};
  assign remap_wr = tgt == MCRA_TGT_PER && req.write
                    && per_addr == REMAP_CTRL_ADDR;

  // remap flag: set by command, cleared only by reset or the pin reset
  always_ff @(posedge clock) begin
    if (reset || !external_reset_n)
      remap_r <= 1'b0;
    else if (remap_wr && req.wdata[REMAP_BIT_POS])
      remap_r <= 1'b1;
  end

  // abort generation
  always_ff @(posedge clock) begin
    if (reset)
      abort <= 1'b0;
    else if (tgt == MCRA_TGT_EXT)
      abort <= !ext_hit;
    else if (tgt == MCRA_TGT_INT)
      abort <= req.write && int_ext_bank
               && (ext_protect || EXT_IS_ROM);
    else
      abort <= 1'b0;
  end

  // internal route; protected writes still issued
  always_ff @(posedge clock) begin
    if (reset) begin
      int_acc          <= '0;
      int_sel_ext_bank <= 1'b0;
    end else begin
      int_acc          <= '0;
      int_acc.valid    <= tgt == MCRA_TGT_INT && int_valid;
      int_acc.write    <= req.write;
      int_acc.addr     <= int_addr;
      int_acc.wdata    <= req.wdata;
      int_acc.lanes    <= mcra_lanes(req.size, req.addr[1:0]);
      int_sel_ext_bank <= int_ext_bank;
    end
  end

  // external route carries the bank timing and width
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_acc <= '0;
    end else begin
      ext_acc            <= '0;
      ext_acc.valid      <= (tgt == MCRA_TGT_EXT && ext_hit) || boot_ext;
      ext_acc.write      <= req.write;
      ext_acc.addr       <= req.addr;
      ext_acc.wdata      <= req.wdata;
      ext_acc.lanes      <= mcra_lanes(req.size, req.addr[1:0]);
      ext_acc.cs         <= boot_ext ? BOOT_CS : ext_cs;
      ext_acc.waits      <= bank[boot_ext ? BOOT_CS : ext_cs].waits;
      ext_acc.float_cyc  <= bank[boot_ext ? BOOT_CS : ext_cs].float_cyc;
      // boot bank width follows the strap until remap
      ext_acc.wide16     <= boot_ext ? !boot_w
                            : bank[ext_cs].wide16;
      ext_acc.byte_write <= !boot_ext && bank[ext_cs].wide16
                            && bank[ext_cs].byte_write;
    end
  end

  // peripheral route: word only, full word-aligned address carried in addr
  always_ff @(posedge clock) begin
    if (reset) begin
      per_acc <= '0;
    end else begin
      per_acc       <= '0;
      per_acc.valid <= tgt == MCRA_TGT_PER;
      per_acc.write <= req.write;
      per_acc.addr  <= per_addr;
      per_acc.wdata <= req.wdata;
      per_acc.lanes <= 4'hF;
      // cs field holds window kind: 1 for the interrupt unit
      per_acc.cs    <= (req.addr >= ICU_BASE) ? 3'h1 : 3'h0;
    end
  end

  // write-one control commands, pulse for one cycle
  always_ff @(posedge clock) begin
    if (reset)
      ctrl_cmd <= 32'h0000_0000;
    else
      ctrl_cmd <= remap_wr ? req.wdata : 32'h0000_0000;
  end

  // registered copies of mode and state
  always_ff @(posedge clock) begin
    if (reset) begin
      remapped      <= 1'b0;
      tristate_mode <= 1'b0;
      boot_sel      <= 1'b0;
      pset_status   <= 32'h0000_0000;
    end else begin
      remapped      <= remap_r;
      tristate_mode <= tri_w;
      boot_sel      <= boot_w;
      pset_status   <= pset_w;
    end
  end

endmodule // mcra_ctrl

// ### mcra_ctrl_asserts.sv
/*
  mcra_ctrl_asserts: port-level checks of the memory controller.
  assumes: bound to mcra_ctrl; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module mcra_ctrl_asserts
  import mcra_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // watched inputs
  input wire logic        external_reset_n,
  input wire logic        tristate_strap_n,
  input wire mcra_req_t   req,
  // watched outputs
  input wire mcra_route_t ext_acc,
  input wire mcra_route_t per_acc,
  input wire logic        abort,
  input wire logic        remapped,
  input wire logic        tristate_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  logic [7:0] low_cnt_r;
  logic [1:0] a_lo;
  logic       per_q;
  logic       ext_q;
  logic       rd_int_q;
  logic       rmp_q;

  // request classes by region
  assign a_lo     = req.addr[1:0];
  assign per_q    = req.valid && req.addr >= PERIPH_BASE;
  assign ext_q    = req.valid && req.addr >= INT_MEM_TOP && !per_q;
  assign rd_int_q = req.valid && !req.write && req.addr < INT_MEM_TOP;
  // any size counts: the low address bits are masked on the way
  assign rmp_q    = req.valid && req.write && req.wdata[0]
                    && {req.addr[31:2], 2'b00} == REMAP_CTRL_ADDR;

  // strap-low run while the pin holds reset; saturates, held after release
  always_ff @(posedge clock) begin
    if (!external_reset_n && tristate_strap_n)
      low_cnt_r <= 8'h00;
    else if (!external_reset_n && low_cnt_r != 8'hFF)
      low_cnt_r <= low_cnt_r + 8'h01;
  end

  property p_per_route;
    per_q |=> per_acc.valid && per_acc.lanes == 4'hF;
  endproperty
  a_per_route: assert property (p_per_route) else $error("peripheral route");

  property p_per_align;
    per_q |=> per_acc.addr[1:0] == 2'b00;
  endproperty
  a_per_align: assert property (p_per_align) else $error("peripheral align");

  property p_no_abort;
    per_q || rd_int_q |=> !abort;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("stray abort");

  property p_ext_answer;
    ext_q |=> abort != ext_acc.valid;
  endproperty
  a_ext_answer: assert property (p_ext_answer) else $error("ext answer");

  property p_ext_lanes;
    ext_q && req.size == 2'h0 |=>
      !ext_acc.valid || ext_acc.lanes == (4'h1 << $past(a_lo));
  endproperty
  a_ext_lanes: assert property (p_ext_lanes) else $error("byte lane");

  property p_cs_early;
    ext_q && !remapped && !$past(rmp_q) |=>
      !ext_acc.valid || ext_acc.cs == 3'h0;
  endproperty
  a_cs_early: assert property (p_cs_early) else $error("early cs");

  property p_remap_set;
    rmp_q && external_reset_n ##1 external_reset_n |=> remapped;
  endproperty
  a_remap_set: assert property (p_remap_set) else $error("remap late");

  property p_remap_hold;
    remapped && external_reset_n |=> remapped;
  endproperty
  a_remap_hold: assert property (p_remap_hold) else $error("remap lost");

  property p_remap_clear;
    // the pin clears the flag one cycle before its registered copy
    disable iff (1'b0) (reset |=> !remapped)
      and (!external_reset_n |-> ##2 !remapped);
  endproperty
  a_remap_clear: assert property (p_remap_clear) else $error("remap kept");

  property p_tristate;
    $rose(tristate_mode) |-> low_cnt_r >= 8'h50;
  endproperty
  a_tristate: assert property (p_tristate) else $error("tristate entry");

  c_abort: cover property (abort);
  c_remap: cover property ($rose(remapped));
  c_tri: cover property ($rose(tristate_mode));
endmodule // mcra_ctrl_asserts

bind mcra_ctrl mcra_ctrl_asserts u_chk (
  .clock(clock), .reset(reset), .external_reset_n(external_reset_n),
  .tristate_strap_n(tristate_strap_n), .req(req), .ext_acc(ext_acc),
  .per_acc(per_acc), .abort(abort), .remapped(remapped),
  .tristate_mode(tristate_mode)
);

// ### mcra_core_model.sv
/*
  mcra_core_model: processor side, one access per call of issue.
  assumes: caller waits for the answer; changes at the falling edge.
*/
`timescale 1ns/1ps
module mcra_core_model
  import mcra_pkg::*;
(
  // clock
  input  wire logic clock,
  // request to the controller
  output mcra_req_t req
);
  initial req = '0;

  // one-cycle request; address and data scrambled afterwards so that
  // nothing downstream can lean on stale values
  task automatic issue(input logic v, input logic w, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
    @(negedge clock);
    req <= '{v, w, 1'b0, sz, a, d};
    @(negedge clock);
    req <= '{1'b0, w, 1'b0, sz, ~a, ~d};
  endtask
endmodule // mcra_core_model

// ### tb.sv
/*
  tb: self-checking bench of the memory controller.
  assumes: mcra_ctrl answers at the taking edge.
*/
`timescale 1ns/1ps
`define chk(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  errors++; $display("wrong value %s expected %0h seen %0h", n, e, s); \
  end end
module tb
  import mcra_pkg::*;
;
  logic        clock, reset, external_reset_n, tristate_strap_n;
  logic        boot_select_strap, ext_protect, pset_en_wr, pset_dis_wr;
  mcra_req_t   req;
  mcra_bank_t  bank [NUM_BANKS];
  mcra_route_t int_acc, ext_acc, per_acc;
  logic        int_sel_ext_bank, abort, remapped, tristate_mode, boot_sel;
  logic [31:0] ctrl_cmd, pset_status;
  int          errors, comparisons;

  mcra_ctrl u_dut (.clock(clock), .reset(reset),
    .external_reset_n(external_reset_n), .tristate_strap_n(tristate_strap_n),
    .boot_select_strap(boot_select_strap), .req(req), .bank(bank),
    .ext_protect(ext_protect), .pset_en_wr(pset_en_wr),
    .pset_dis_wr(pset_dis_wr), .int_acc(int_acc), .ext_acc(ext_acc),
    .per_acc(per_acc), .int_sel_ext_bank(int_sel_ext_bank), .abort(abort),
    .remapped(remapped), .tristate_mode(tristate_mode), .boot_sel(boot_sel),
    .ctrl_cmd(ctrl_cmd), .pset_status(pset_status));
  mcra_core_model u_core (.clock(clock), .req(req));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one access; issue returns at the falling edge after the answer edge,
  // the only falling edge at which the one-cycle answer stands
  task automatic acc(input logic w, input logic [1:0] sz,
                     input logic [31:0] a, input logic [31:0] d);
    u_core.issue(1'b1, w, sz, a, d);
  endtask

  // pin reset long enough for both strap windows
  task automatic pin_reset(input logic tri_n, input logic boot);
    @(negedge clock);
    external_reset_n = 1'b0;
    tristate_strap_n = tri_n;
    boot_select_strap = boot;
    repeat (85) @(negedge clock);
    external_reset_n = 1'b1;
    tristate_strap_n = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  task automatic t_straps;
    pin_reset(1'b0, 1'b1);
    `chk("tristate_mode", 1'b1, tristate_mode)
    `chk("boot_sel", 1'b1, boot_sel)
    acc(1'b0, 2'h2, 32'h0000_0000, 32'h0000_0000);
    `chk("xboot valid", 1'b1, int_acc.valid)
    `chk("xboot sel", 1'b1, int_sel_ext_bank)
    `chk("xboot addr", EXT_SRAM_BASE, int_acc.addr)
    pin_reset(1'b1, 1'b0);
    `chk("tristate_mode", 1'b0, tristate_mode)
    `chk("boot_sel", 1'b0, boot_sel)
    `chk("remapped", 1'b0, remapped)
  endtask

  task automatic t_boot;
    acc(1'b0, 2'h2, 32'h0000_0000, 32'h0000_0000);
    `chk("boot ext valid", 1'b1, ext_acc.valid)
    `chk("boot cs", 3'h0, ext_acc.cs)
    acc(1'b0, 2'h2, 32'h0100_0000, 32'h0000_0000);
    `chk("cs1 abort", 1'b1, abort)
    `chk("cs1 valid", 1'b0, ext_acc.valid)
  endtask

  task automatic t_remap;
    acc(1'b1, 2'h0, 32'hFFE0_0021, 32'h0000_0001);
    `chk("ctrl addr", REMAP_CTRL_ADDR, per_acc.addr)
    `chk("ctrl lanes", 4'hF, per_acc.lanes)
    `chk("ctrl_cmd", 32'h0000_0001, ctrl_cmd)
    @(negedge clock);
    `chk("remapped", 1'b1, remapped)
    acc(1'b0, 2'h2, 32'h0100_0000, 32'h0000_0000);
    `chk("cs1 valid", 1'b1, ext_acc.valid)
    `chk("cs1 cs", 3'h1, ext_acc.cs)
    acc(1'b0, 2'h2, 32'h0000_0004, 32'h0000_0000);
    `chk("sram valid", 1'b1, int_acc.valid)
    `chk("sram ext bank", 1'b0, int_sel_ext_bank)
    `chk("sram addr", PRIM_SRAM_BASE | 32'h0000_0004, int_acc.addr)
    acc(1'b1, 2'h2, REMAP_CTRL_ADDR, 32'h0000_0000);
    `chk("ctrl_cmd zero", 32'h0000_0000, ctrl_cmd)
    @(negedge clock);
    `chk("remap kept", 1'b1, remapped)
  endtask

  task automatic t_abort;
    acc(1'b0, 2'h2, 32'h0800_0000, 32'h0000_0000);
    `chk("undef abort", 1'b1, abort)
    acc(1'b0, 2'h2, 32'hFFC1_0000, 32'h0000_0000);
    `chk("per abort", 1'b0, abort)
    `chk("per valid", 1'b1, per_acc.valid)
    acc(1'b0, 2'h2, 32'hFFFF_F004, 32'h0000_0000);
    `chk("icu cs", 3'h1, per_acc.cs)
    acc(1'b0, 2'h2, EXT_SRAM_BASE, 32'h0000_0000);
    `chk("xbank sel", 1'b1, int_sel_ext_bank)
    `chk("xbank abort", 1'b0, abort)
    ext_protect = 1'b1;
    acc(1'b1, 2'h2, EXT_SRAM_BASE, 32'h1234_5678);
    `chk("prot abort", 1'b1, abort)
    `chk("prot valid", 1'b1, int_acc.valid)
    ext_protect = 1'b0;
  endtask

  task automatic t_lanes;
    logic [3:0] exp_l [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, (i < 4) ? 2'h0 : 2'h1, 32'h0040_0000 + 32'(i % 4 * 2 ** (i / 4)),
          32'hA1B2_C3D4);
      `chk("ext lanes", exp_l[i], ext_acc.lanes)
    end
    `chk("ext waits", 4'h3, ext_acc.waits)
    `chk("ext float", 2'h1, ext_acc.float_cyc)
    `chk("ext wide16", 1'b1, ext_acc.wide16)
    `chk("ext byte_write", 1'b1, ext_acc.byte_write)
  endtask

  // enable or disable through the shadow command pair
  task automatic t_bitset(input logic en, input logic [31:0] d,
                          input logic [31:0] exp);
    fork
      u_core.issue(1'b0, 1'b1, 2'h2, 32'hFFFF_0000, d);
      begin
        @(negedge clock);
        pset_en_wr = en;
        pset_dis_wr = !en;
        @(negedge clock);
        pset_en_wr = 1'b0;
        pset_dis_wr = 1'b0;
      end
    join
    // status is registered once more on its way to the port
    @(negedge clock);
    `chk("pset_status", exp, pset_status)
  endtask

  task automatic t_reset;
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    `chk("remap after reset", 1'b0, remapped)
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    reset = 1'b1;
    external_reset_n = 1'b0;
    tristate_strap_n = 1'b1;
    boot_select_strap = 1'b0;
    ext_protect = 1'b0;
    pset_en_wr = 1'b0;
    pset_dis_wr = 1'b0;
    foreach (bank[i]) bank[i] = '0;
    bank[0] = '{1'b1, 32'h0040_0000, 32'h0010_0000, 4'h3, 2'h1, 1'b1, 1'b1};
    bank[1] = '{1'b1, 32'h0100_0000, 32'h0010_0000, 4'h0, 2'h0, 1'b0, 1'b0};
    repeat (3) @(negedge clock);
    reset = 1'b0;
    t_straps();
    t_boot();
    t_remap();
    t_abort();
    t_lanes();
    t_bitset(1'b1, 32'h0000_00A5, 32'h0000_00A5);
    t_bitset(1'b0, 32'h0000_0005, 32'h0000_00A0);
    t_reset();
    conclude();
  end

  // hang guard
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule // tb
